// [tws_eeprom_slave.sv]
// Two-wire serial EEPROM slave with array, write guard and APB control
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module tws_eeprom_slave
    import tws_pkg::*;
#(
    parameter int WR_CYC = WR_CYCLES
) (
    // Clock and reset
    input  wire logic              mclk_i,
    input  wire logic              rst_i,
    // Two-wire pins
    input  wire logic              scl_i,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe_o,
    input  wire logic [SEL_W-1:0]  strap_addr_i,
    input  wire logic              wp_i,
    // APB slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [APB_AW-1:0] paddr_i,
    input  wire logic [APB_DW-1:0] pwdata_i,
    output logic      [APB_DW-1:0] prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    // Status
    output logic                   standby_o
);
    localparam int SYNC_W = SEL_W + 3;

    tws_core_t          r;
    tws_core_t          n;
    logic [BYTE_W-1:0]  mem [MEM_DEPTH];
    logic [SYNC_W-1:0]  sync_q;
    logic               scl_s;
    logic               sda_s;
    logic               wp_s;
    logic [SEL_W-1:0]   strap_s;
    logic [SEL_W-1:0]   smask;
    logic [ADDR_W-1:0]  amask;
    logic [ADDR_W-1:0]  pmask;
    logic               rise_c;
    logic               fall_c;
    logic               start_c;
    logic               stop_c;
    logic               dev_match;
    logic               dec_c;
    logic [ADDR_W-1:0]  page_hi;
    logic [ADDR_W-1:0]  addr_rd_inc;
    logic [ADDR_W-1:0]  addr_wr_inc;
    logic [BYTE_W-1:0]  rd_byte;
    logic [APB_DW-1:0]  status_word;
    logic               mem_we;
    logic               tmr_start;

    tws_tmr_if tmr_bus ();

    initial begin
        if (WR_CYC < 1) $error("tws_eeprom_slave: WR_CYC must be positive");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and write cycle timer

    tws_sync #(
        .W (SYNC_W)
    ) u_sync (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .d_i    ({wp_i, strap_addr_i, sda_i, scl_i}),
        .q_o    (sync_q)
    );

    assign {wp_s, strap_s, sda_s, scl_s} = sync_q;

    tws_wr_timer #(
        .CYC (WR_CYC)
    ) u_timer (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .tb     (tmr_bus.tmr)
    );

    assign tmr_bus.start = tmr_start;

    ////////////////////////////////////////////////////////////////////////
    // Density decode and bus conditions

    always_comb begin
        unique case (r.density)
            DEN_2K: begin
                smask = SMASK_2K;
                amask = AMASK_2K;
                pmask = PMASK_8B;
            end
            DEN_4K: begin
                smask = SMASK_4K;
                amask = AMASK_4K;
                pmask = PMASK_16B;
            end
            DEN_8K: begin
                smask = SMASK_8K;
                amask = AMASK_8K;
                pmask = PMASK_16B;
            end
            DEN_16K: begin
                smask = SMASK_16K;
                amask = AMASK_16K;
                pmask = PMASK_16B;
            end
        endcase
    end

    assign rise_c  = scl_s && !r.scl_q;
    assign fall_c  = !scl_s && r.scl_q;
    assign start_c = scl_s && r.scl_q && r.sda_q && !sda_s;
    assign stop_c  = scl_s && r.scl_q && !r.sda_q && sda_s;
    // Header, strap compare and busy gate for the device address word
    assign dev_match = (r.shreg[HDR_MSB:HDR_LSB] == DEV_HDR)
        && (((r.shreg[SEL_MSB:SEL_LSB] ^ strap_s) & smask) == '0)
        && !tmr_bus.busy;
    assign dec_c = (r.st == ST_RX) && fall_c && (r.cnt == BITS_PER_BYTE);
    // Page select bits land above the eight word address bits
    assign page_hi = ADDR_W'(r.shreg[SEL_MSB:SEL_LSB] & ~smask)
        << BYTE_W;
    assign addr_rd_inc = (r.addr + 1'b1) & amask;
    assign addr_wr_inc = (r.addr & ~pmask) | ((r.addr + 1'b1) & pmask);
    assign rd_byte = mem[r.addr];

    always_comb begin
        status_word = '0;
        status_word[STS_BUSY] = tmr_bus.busy;
        status_word[STS_STBY] = r.standby;
        status_word[STS_WP]   = wp_s;
        status_word[STS_ACT]  = (r.st != ST_IDLE);
        status_word[STS_ADDR +: ADDR_W] = r.addr;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        n         = r;
        mem_we    = 1'b0;
        tmr_start = 1'b0;
        n.scl_q   = scl_s;
        n.sda_q   = sda_s;
        n.pready  = 1'b0;
        n.pslverr = 1'b0;

        // APB: zero wait, answer in the first access cycle
        if (psel_i && !penable_i) begin
            n.pready = 1'b1;
            case (paddr_i)
                OFF_CTRL:   n.prdata = APB_DW'(r.density);
                OFF_STATUS: n.prdata = status_word;
                default: begin
                    n.prdata  = '0;
                    n.pslverr = 1'b1;
                end
            endcase
        end
        if (psel_i && penable_i && r.pready && pwrite_i
            && paddr_i == OFF_CTRL) begin
            n.density = tws_den_t'(pwdata_i[DEN_W-1:0]);
            n.addr    = '0; // Counter must not point past a smaller array
        end

        // Two-wire protocol
        if (start_c) begin
            n.st     = ST_RX;
            n.ph     = PH_DEV;
            n.cnt    = '0;
            n.sda_oe = 1'b0;
            n.wrote  = 1'b0;
            tmr_start = r.wrote;
        end else if (stop_c) begin
            n.st     = ST_IDLE;
            n.sda_oe = 1'b0;
            n.wrote  = 1'b0;
            tmr_start = r.wrote;
        end else begin
            unique case (r.st)
                ST_IDLE: begin
                    n.sda_oe = 1'b0;
                end
                ST_RX: begin
                    if (rise_c) begin
                        n.shreg = {r.shreg[BYTE_W-2:0], sda_s};
                        n.cnt   = r.cnt + 1'b1;
                    end
                    if (dec_c) begin
                        n.cnt = '0;
                        n.st  = ST_ACK;
                        n.sda_oe = 1'b1;
                        unique case (r.ph)
                            PH_DEV: begin
                                if (dev_match) begin
                                    n.rw = r.shreg[RW_BIT];
                                    if (!r.shreg[RW_BIT]) begin
                                        n.addr = page_hi & amask;
                                    end
                                end else begin
                                    n.st     = ST_IDLE;
                                    n.sda_oe = 1'b0;
                                end
                            end
                            PH_WORD: begin
                                n.addr = (r.addr & ~AMASK_2K
                                    | ADDR_W'(r.shreg)) & amask;
                            end
                            PH_DATA: begin
                                mem_we  = !wp_s;
                                n.wrote = r.wrote || !wp_s;
                                n.addr  = addr_wr_inc;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (fall_c) begin
                        n.sda_oe = 1'b0;
                        if (r.rw) begin
                            n.st     = ST_TX;
                            n.shreg  = rd_byte;
                            n.sda_oe = !rd_byte[BYTE_W-1];
                            n.cnt    = '0;
                        end else begin
                            n.st = ST_RX;
                            n.ph = (r.ph == PH_DEV) ? PH_WORD : PH_DATA;
                        end
                    end
                end
                ST_TX: begin
                    if (fall_c) begin
                        if (r.cnt == LAST_TX_BIT) begin
                            n.sda_oe = 1'b0;
                            n.st     = ST_MACK;
                            n.mack   = 1'b0;
                            n.addr   = addr_rd_inc;
                        end else begin
                            n.cnt    = r.cnt + 1'b1;
                            n.shreg  = {r.shreg[BYTE_W-2:0], 1'b0};
                            n.sda_oe = !r.shreg[BYTE_W-2];
                        end
                    end
                end
                ST_MACK: begin
                    if (rise_c) begin
                        n.mack = !sda_s;
                    end
                    if (fall_c) begin
                        if (r.mack) begin
                            n.st     = ST_TX;
                            n.shreg  = rd_byte;
                            n.sda_oe = !rd_byte[BYTE_W-1];
                            n.cnt    = '0;
                        end else begin
                            n.st = ST_IDLE;
                        end
                    end
                end
            endcase
        end
        // Standby once idle and no write cycle is running
        n.standby = (n.st == ST_IDLE) && !tmr_bus.busy && !tmr_start;
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers and array

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= CORE_RST;
        end else begin
            r <= n;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (mem_we) begin
            mem[r.addr] <= r.shreg;
        end
    end

    assign sda_o     = r.sda_lvl;
    assign sda_oe_o  = r.sda_oe;
    assign prdata_o  = r.prdata;
    assign pready_o  = r.pready;
    assign pslverr_o = r.pslverr;
    assign standby_o = r.standby;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_decide;
        dec_c && r.ph == PH_DEV;
    endsequence

    sequence s_held_ack;
        r.st == ST_ACK && r.sda_oe;
    endsequence

    ack_on_match_a: assert property (
        s_decide ##0 dev_match |=> s_held_ack)
        else $error("matching address word not acknowledged");
    busy_nack_a: assert property (
        s_decide ##0 tmr_bus.busy |=> !r.sda_oe && r.st == ST_IDLE)
        else $error("address word acknowledged during write cycle");
    header_chk_a: assert property (
        s_decide ##0 (r.shreg[HDR_MSB:HDR_LSB] != DEV_HDR) |=> !r.sda_oe)
        else $error("wrong header acknowledged");
    start_restart_a: assert property (
        start_c |=> r.st == ST_RX && r.cnt == '0 && r.ph == PH_DEV)
        else $error("start did not restart framing");
    stop_idle_a: assert property (
        stop_c |=> r.st == ST_IDLE && !r.sda_oe)
        else $error("stop did not release and idle");
    guard_block_a: assert property (
        mem_we |-> !wp_s && r.ph == PH_DATA)
        else $error("array written while guarded");
    sda_on_fall_a: assert property (
        $changed(r.sda_oe)
        |-> $past(fall_c || start_c || stop_c || r.st == ST_IDLE))
        else $error("data line changed off the clock fall");
    addr_range_a: assert property (
        (r.addr & ~amask) == '0 || $changed(r.density))
        else $error("address outside the array");
    ninth_ack_a: assert property (
        dec_c && r.ph != PH_DEV |=> s_held_ack ##1 r.sda_oe)
        else $error("received byte not acknowledged");
    timer_go_a: assert property (
        tmr_start && !tmr_bus.busy |=> tmr_bus.busy && !r.standby)
        else $error("write cycle did not start");
endmodule // tws_eeprom_slave

// [tws_eeprom_slave_bench.sv]
// Self-checking bench for the two-wire EEPROM slave
`timescale 1ns/1ps
module tws_eeprom_slave_bench;
    import tws_pkg::*;
    localparam int WRC = 2000;
    logic        mclk = 1'b0, rst = 1'b1, wp = 1'b0;
    logic [2:0]  strap = 3'h5;
    logic        scl, m_oe, sda_oe, sda_o, sby, ack, err;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pready, pslverr;
    logic [7:0]  paddr = 8'h00;
    logic [7:0]  db;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int          num_errors = 0, n_compared = 0;
    // Pulled-up wire shared by both open-drain drivers
    wire         sda = ~((sda_oe & ~sda_o) | m_oe);
    always #2 mclk = ~mclk;

    tws_eeprom_slave #(.WR_CYC(WRC)) tws_eeprom_slave_i (
        .mclk_i(mclk), .rst_i(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .strap_addr_i(strap), .wp_i(wp), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .standby_o(sby));
    tws_master_mdl tws_master_mdl_i (.mclk_i(mclk), .sda_i(sda),
        .scl_o(scl), .sda_oe_o(m_oe));

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("pready", 32'h1, 32'(pready));
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic lk_w(input logic [7:0] d, input logic e);
        tws_master_mdl_i.wbyte(d, ack);
        chk("ack", 32'(e), 32'(ack));
    endtask
    task automatic wr2(input logic [2:0] s, input logic [7:0] wa, b0, b1);
        tws_master_mdl_i.start();
        lk_w({4'ha, s, 1'b0}, 1'b1);
        lk_w(wa, 1'b1);
        lk_w(b0, 1'b1);
        lk_w(b1, 1'b1);
        tws_master_mdl_i.stop();
    endtask
    task automatic rd1(input logic [2:0] s, input logic [7:0] wa, e);
        tws_master_mdl_i.start();
        lk_w({4'ha, s, 1'b0}, 1'b1);
        lk_w(wa, 1'b1);
        tws_master_mdl_i.start();
        lk_w({4'ha, s, 1'b1}, 1'b1);
        tws_master_mdl_i.rbyte(1'b0, db);
        tws_master_mdl_i.stop();
        chk("rdata", 32'(e), 32'(db));
    endtask
    task automatic t_regs();
        chk("standby_o", 32'h1, 32'(sby));
        apb(1'b0, OFF_CTRL, 32'h0);
        chk("ctrl", 32'(CTRL_DEN_RST), rd);
        apb(1'b1, OFF_STATUS, 32'hffff_ffff);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status", 32'h2, rd);
        apb(1'b0, 8'h10, 32'h0);
        chk("pslverr", 32'h1, 32'(err));
        $display("register test done");
    endtask
    task automatic t_sel();
        logic [2:0] msk [4] = '{SMASK_2K, SMASK_4K, SMASK_8K, SMASK_16K};
        for (int d = 0; d < 4; d++) begin
            apb(1'b1, OFF_CTRL, 32'(d));
            strap <= d[0] ? 3'h5 : 3'h6;
            for (int s = 0; s < 9; s++) begin
                tws_master_mdl_i.start();
                if (s == 8)
                    lk_w(8'hb4, 1'b0);
                else
                    lk_w({4'ha, 3'(s), 1'b0},
                         ((3'(s) ^ strap) & msk[d]) == 3'h0);
                tws_master_mdl_i.stop();
            end
        end
        $display("select test done");
    endtask
    task automatic t_page(input logic [1:0] den, input logic [2:0] s,
                          input logic [7:0] lo);
        int n;
        apb(1'b1, OFF_CTRL, 32'(den));
        wr2(s, 8'hff, {den, 6'h11}, {den, 6'h22});
        tws_master_mdl_i.start();
        lk_w({4'ha, s, 1'b0}, 1'b0);
        tws_master_mdl_i.stop();
        chk("standby_busy", 32'h0, 32'(sby));
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status_busy", 32'h1, rd & 32'h0000_000f);
        n = 0;
        while (sby !== 1'b1 && n < 3 * WRC) begin
            @(posedge mclk);
            n++;
        end
        chk("standby_end", 32'h1, 32'(sby));
        rd1(s, lo, {den, 6'h22});
        rd1(s, 8'hff, {den, 6'h11});
        $display("page test %0d done", den);
    endtask
    task automatic t_wp();
        wp <= 1'b1;
        wr2(3'h6, 8'hff, 8'h5a, 8'h5b);
        tws_master_mdl_i.start();
        lk_w(8'hac, 1'b1);
        tws_master_mdl_i.stop();
        repeat (8) @(posedge mclk);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status_wp", 32'h0600_0006, rd);
        wp <= 1'b0;
        rd1(3'h6, 8'hff, 8'hd1);
        $display("guard test done");
    endtask
    task automatic t_abort();
        tws_master_mdl_i.start();
        repeat (3) tws_master_mdl_i.bit_io(1'b1, ack);
        rd1(3'h6, 8'hf0, 8'he2);
        $display("abort test done");
    endtask
    task automatic t_seq();
        int n;
        wr2(3'h6, 8'h40, 8'h3c, 8'h3d);
        repeat (8) @(posedge mclk);
        n = 0;
        while (sby !== 1'b1 && n < 3 * WRC) begin
            @(posedge mclk);
            n++;
        end
        chk("standby_seq", 32'h1, 32'(sby));
        tws_master_mdl_i.start();
        lk_w(8'hac, 1'b1);
        lk_w(8'h40, 1'b1);
        tws_master_mdl_i.start();
        lk_w(8'had, 1'b1);
        tws_master_mdl_i.rbyte(1'b1, db);
        chk("seq0", 32'h3c, 32'(db));
        chk("standby_act", 32'h0, 32'(sby));
        tws_master_mdl_i.rbyte(1'b0, db);
        tws_master_mdl_i.stop();
        chk("seq1", 32'h3d, 32'(db));
        repeat (8) @(posedge mclk);
        chk("standby_rd", 32'h1, 32'(sby));
        $display("sequential test done");
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        t_regs();
        t_sel();
        t_page(2'h0, 3'h5, 8'hf8);
        t_page(2'h1, 3'h5, 8'hf0);
        t_page(2'h2, 3'h7, 8'hf0);
        t_page(2'h3, 3'h6, 8'hf0);
        t_wp();
        t_abort();
        t_seq();
        test_done();
    end
    initial begin
        repeat (90000) @(posedge mclk);
        num_errors++;
        test_done();
    end
endmodule // tws_eeprom_slave_bench

// [tws_master_mdl.sv]
// Two-wire bus master model that drives the serial clock and data pins
`timescale 1ns/1ps
module tws_master_mdl (
    // Clock
    input  wire logic mclk_i,
    // Two-wire pins
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_o
);
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // Quarter of the 160 ns serial clock period
    task automatic q();
        repeat (10) @(posedge mclk_i);
    endtask
    task automatic start();
        q();
        sda_oe_o <= 1'b0;
        q();
        scl_o <= 1'b1;
        q();
        sda_oe_o <= 1'b1;
        q();
        scl_o <= 1'b0;
    endtask
    task automatic stop();
        q();
        sda_oe_o <= 1'b1;
        q();
        scl_o <= 1'b1;
        q();
        sda_oe_o <= 1'b0;
    endtask
    // Data moves only while the clock is low
    task automatic bit_io(input logic b, output logic r);
        q();
        sda_oe_o <= ~b;
        q();
        scl_o <= 1'b1;
        q();
        r = sda_i;
        q();
        scl_o <= 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic rbyte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~more, r);
    endtask
endmodule // tws_master_mdl

// [tws_pkg.sv]
// Constants, types and reset values shared by the two-wire EEPROM slave
package tws_pkg;

    // Timing
    localparam int CLK_MHZ   = 250;
    localparam int T_WR_MS   = 5;
    localparam int WR_CYCLES = T_WR_MS * 1000 * CLK_MHZ;

    // Array and framing
    localparam int ADDR_W    = 11;
    localparam int MEM_DEPTH = 2048;
    localparam int BYTE_W    = 8;
    localparam int CNT_W     = 4;
    localparam int SEL_W     = 3;
    localparam int DEN_W     = 2;
    localparam logic [CNT_W-1:0] BITS_PER_BYTE = 4'h8;
    localparam logic [CNT_W-1:0] LAST_TX_BIT   = 4'h7;
    localparam logic [3:0]       DEV_HDR       = 4'ha;
    localparam int HDR_MSB = 7;
    localparam int HDR_LSB = 4;
    localparam int SEL_MSB = 3;
    localparam int SEL_LSB = 1;
    localparam int RW_BIT  = 0;
    localparam int WA_MSB  = 7;

    // Density dependent masks
    typedef enum logic [1:0] {
        DEN_2K  = 2'h0,
        DEN_4K  = 2'h1,
        DEN_8K  = 2'h2,
        DEN_16K = 2'h3
    } tws_den_t;
    localparam logic [SEL_W-1:0]  SMASK_2K  = 3'h7;
    localparam logic [SEL_W-1:0]  SMASK_4K  = 3'h6;
    localparam logic [SEL_W-1:0]  SMASK_8K  = 3'h4;
    localparam logic [SEL_W-1:0]  SMASK_16K = 3'h0;
    localparam logic [ADDR_W-1:0] AMASK_2K  = 11'h0ff;
    localparam logic [ADDR_W-1:0] AMASK_4K  = 11'h1ff;
    localparam logic [ADDR_W-1:0] AMASK_8K  = 11'h3ff;
    localparam logic [ADDR_W-1:0] AMASK_16K = 11'h7ff;
    localparam logic [ADDR_W-1:0] PMASK_8B  = 11'h007;
    localparam logic [ADDR_W-1:0] PMASK_16B = 11'h00f;

    // APB map
    localparam int APB_AW = 8;
    localparam int APB_DW = 32;
    localparam logic [APB_AW-1:0] OFF_CTRL   = 8'h00;
    localparam logic [APB_AW-1:0] OFF_STATUS = 8'h04;
    localparam tws_den_t CTRL_DEN_RST = DEN_2K;
    localparam int STS_BUSY  = 0;
    localparam int STS_STBY  = 1;
    localparam int STS_WP    = 2;
    localparam int STS_ACT   = 3;
    localparam int STS_ADDR  = 16;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX   = 5'h02,
        ST_ACK  = 5'h04,
        ST_TX   = 5'h08,
        ST_MACK = 5'h10
    } tws_state_t;

    typedef enum logic [2:0] {
        PH_DEV  = 3'h1,
        PH_WORD = 3'h2,
        PH_DATA = 3'h4
    } tws_phase_t;

    typedef struct packed {
        tws_state_t         st;
        tws_phase_t         ph;
        logic [CNT_W-1:0]   cnt;
        logic [BYTE_W-1:0]  shreg;
        logic               rw;
        logic               mack;
        logic               wrote;
        logic [ADDR_W-1:0]  addr;
        logic               sda_oe;
        logic               sda_lvl;
        logic               scl_q;
        logic               sda_q;
        tws_den_t           density;
        logic               pready;
        logic               pslverr;
        logic [APB_DW-1:0]  prdata;
        logic               standby;
    } tws_core_t;

    localparam tws_core_t CORE_RST = '{
        st: ST_IDLE, ph: PH_DEV, cnt: '0, shreg: '0, rw: 1'b0,
        mack: 1'b0, wrote: 1'b0, addr: '0, sda_oe: 1'b0,
        sda_lvl: 1'b0, scl_q: 1'b0, sda_q: 1'b0,
        density: CTRL_DEN_RST, pready: 1'b0, pslverr: 1'b0,
        prdata: '0, standby: 1'b1};

endpackage

// [tws_sync.sv]
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module tws_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } tws_sync_st_t;

    tws_sync_st_t sync_reg;
    tws_sync_st_t sync_next;

    initial begin
        if (W < 1) $error("tws_sync: W must be at least 1");
    end

    always_comb begin
        sync_next.s1 = d_i;
        sync_next.s2 = sync_reg.s1;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign q_o = sync_reg.s2;
endmodule // tws_sync

// [tws_tmr_if.sv]
// Handshake between the transfer logic and the write cycle timer
`timescale 1ns/1ps
interface tws_tmr_if;
    logic start;
    logic busy;
    modport ctl (output start, input busy);
    modport tmr (input start, output busy);
endinterface

// [tws_wr_timer.sv]
// Self-timed nonvolatile write cycle timer
`timescale 1ns/1ps
module tws_wr_timer
    import tws_pkg::*;
#(
    parameter int CYC = WR_CYCLES
) (
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_i,
    // Control
    tws_tmr_if.tmr    tb
);
    localparam int CW = $clog2(CYC + 1);

    typedef struct packed {
        logic          busy;
        logic [CW-1:0] cnt;
    } tws_tmr_st_t;

    tws_tmr_st_t tmr_reg;
    tws_tmr_st_t tmr_next;

    initial begin
        if (CYC < 1) $error("tws_wr_timer: CYC must be at least 1");
    end

    always_comb begin
        tmr_next = tmr_reg;
        if (tb.start && !tmr_reg.busy) begin
            tmr_next.busy = 1'b1;
            tmr_next.cnt  = CW'(CYC - 1);
        end else if (tmr_reg.busy) begin
            if (tmr_reg.cnt == '0) begin
                tmr_next.busy = 1'b0;
            end else begin
                tmr_next.cnt = tmr_reg.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tmr_reg <= '0;
        end else begin
            tmr_reg <= tmr_next;
        end
    end

    assign tb.busy = tmr_reg.busy;
endmodule // tws_wr_timer
